// file: logic/first_fault_and_input_voltage_regs.sv
// first-fault code and derived input-voltage registers behind an apb slave
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "ffiv_regs.svh"
module first_fault_and_input_voltage_regs #(
  parameter int SENSE_W    = 12,
  parameter int MOD_W      = 8,
  parameter int SAMPLE_CYC = `VIN_SAMPLE_CYC
) (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               resetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic [31:0]             prdata,
  // protection flags
  input  wire logic               core_supply_overvoltage,
  input  wire logic               main_supply_overvoltage,
  input  wire logic               config_checksum_error,
  input  wire logic               input_current_fast_trip,
  input  wire logic               input_current_precise_trip,
  input  wire logic               output_current_precise_trip,
  input  wire logic               load_side_overvoltage,
  input  wire logic               local_overvoltage,
  input  wire logic               external_fault_input,
  input  wire logic               overtemperature,
  input  wire logic               undervoltage,
  input  wire logic               reverse_voltage,
  input  wire logic               voltage_continuity_error,
  input  wire logic               share_bus_fault,
  input  wire logic               line_sense_fault,
  input  wire logic               supply_restart,
  // measurements
  input  wire logic [SENSE_W-1:0] local_output_sense,
  input  wire logic [MOD_W-1:0]   pwm_modulation,
  // interrupt
  output logic                    irq
);
  localparam int TICK_W = $clog2(SAMPLE_CYC + 1);

  logic [15:1]           flag_vec;
  logic [15:1]           flag_prev_reg;
  logic [15:1]           flag_rise;
  ffiv_pkg::fault_code_t first_code;
  ffiv_pkg::fault_code_t fault_code_reg;
  logic                  fault_clear;
  logic [15:0]           vin_reg;
  logic [7:0]            lo_pend_reg;
  logic [7:0]            lo_snap_reg;
  logic                  second_byte_reg;
  logic [`IRQ_W-1:0]     status_reg;
  logic [`IRQ_W-1:0]     mask_reg;
  logic [`IRQ_W-1:0]     status_set;
  logic                  sample_en_reg;
  logic [TICK_W-1:0]     tick_cnt_reg;
  logic                  tick;
  logic                  div_done;
  logic                  div_zero;
  logic [15:0]           div_quo;
  logic                  setup;
  logic                  access;
  logic [7:0]            idx;
  logic                  hit;
  logic                  rd_fault;
  logic                  rd_vin;
  logic                  wr_status;
  logic                  wr_mask;
  logic                  wr_ctrl;

  // ----------------------------------------------------------------
  // flag edges and first-fault priority
  // ----------------------------------------------------------------
  assign flag_vec = {line_sense_fault, share_bus_fault, voltage_continuity_error,
                     reverse_voltage, undervoltage, overtemperature,
                     external_fault_input, local_overvoltage, load_side_overvoltage,
                     output_current_precise_trip, input_current_precise_trip,
                     input_current_fast_trip, config_checksum_error,
                     main_supply_overvoltage, core_supply_overvoltage};
  assign flag_rise = flag_vec & ~flag_prev_reg;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flag_prev_reg <= '0;
    end else begin
      flag_prev_reg <= flag_vec;
    end
  end

  // lowest code wins when flags rise together
  always_comb begin
    first_code = `CODE_NONE;
    for (int i = 15; i >= 1; i--) begin
      if (flag_rise[i]) begin
        first_code = 4'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign idx       = paddr[9:2];
  assign hit       = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                     (idx == `FAULT_CODE_IDX || idx == `VIN_VALUE_IDX ||
                      idx == `IRQ_STATUS_IDX || idx == `IRQ_MASK_IDX ||
                      idx == `CONTROL_IDX);
  assign pready    = access;
  assign pslverr   = access && !hit;
  assign rd_fault  = access && !pwrite && hit && idx == `FAULT_CODE_IDX;
  assign rd_vin    = access && !pwrite && hit && idx == `VIN_VALUE_IDX;
  assign wr_status = access && pwrite && hit && idx == `IRQ_STATUS_IDX;
  assign wr_mask   = access && pwrite && hit && idx == `IRQ_MASK_IDX;
  assign wr_ctrl   = access && pwrite && hit && idx == `CONTROL_IDX;

  // clear only what was returned, so a code caught during the setup cycle survives
  assign fault_clear = supply_restart ||
                       (rd_fault && prdata[3:0] == fault_code_reg);

  // ----------------------------------------------------------------
  // first-fault register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fault_code_reg <= `CODE_NONE;
    end else if (first_code != `CODE_NONE &&
                 (fault_code_reg == `CODE_NONE || fault_clear)) begin
      fault_code_reg <= first_code;
    end else if (fault_clear) begin
      fault_code_reg <= `CODE_NONE;
    end
  end

  // ----------------------------------------------------------------
  // sample rate tick and divider
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  assign tick = (tick_cnt_reg == TICK_W'(SAMPLE_CYC - 1));

  vin_divider #(
    .SENSE_W (SENSE_W),
    .MOD_W   (MOD_W),
    .OUT_W   (16)
  ) u_div (
    .mclk       (mclk),
    .resetn     (resetn),
    .start      (tick && sample_en_reg),
    .sense      (local_output_sense),
    .modulation (pwm_modulation),
    .done       (div_done),
    .div_zero   (div_zero),
    .quotient   (div_quo)
  );

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      vin_reg <= '0;
    end else if (div_done) begin
      vin_reg <= div_quo;
    end
  end

  // ----------------------------------------------------------------
  // two-read byte sequencing of the input voltage
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      second_byte_reg <= 1'b0;
      lo_pend_reg     <= '0;
      lo_snap_reg     <= '0;
    end else begin
      if (setup) begin
        lo_pend_reg <= vin_reg[7:0];
      end
      if (rd_vin && !second_byte_reg) begin
        lo_snap_reg     <= lo_pend_reg;
        second_byte_reg <= 1'b1;
      end else if (access) begin
        second_byte_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data, latched in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prdata <= '0;
    end else if (setup && !pwrite) begin
      prdata <= '0;
      if (paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00) begin
        unique case (idx)
          `FAULT_CODE_IDX: prdata[3:0] <= fault_code_reg;
          `VIN_VALUE_IDX:  prdata[7:0] <= second_byte_reg ? lo_snap_reg
                                                          : vin_reg[15:8];
          `IRQ_STATUS_IDX: prdata[`IRQ_W-1:0] <= status_reg;
          `IRQ_MASK_IDX:   prdata[`IRQ_W-1:0] <= mask_reg;
          `CONTROL_IDX:    prdata[`CTRL_SAMPLE_BIT] <= sample_en_reg;
          default:         prdata <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // control and interrupt registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sample_en_reg <= `CTRL_RESET;
      mask_reg      <= `MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        sample_en_reg <= pwdata[`CTRL_SAMPLE_BIT];
      end
      if (wr_mask) begin
        mask_reg <= pwdata[`IRQ_W-1:0];
      end
    end
  end

  always_comb begin
    status_set = '0;
    status_set[`IRQ_FAULT_BIT] = first_code != `CODE_NONE &&
                                 (fault_code_reg == `CODE_NONE || fault_clear);
    status_set[`IRQ_VIN_BIT]   = div_done;
    status_set[`IRQ_ZERO_BIT]  = div_done && div_zero;
  end

  // write one to clear, a new event wins
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~(wr_status ? pwdata[`IRQ_W-1:0] : '0)) | status_set;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  fault_read_width_a: assert property (
    rd_fault |-> prdata[31:4] == '0)
    else $error("fault read has upper bits set");

  fault_restart_a: assert property (
    supply_restart && first_code == `CODE_NONE |=> fault_code_reg == `CODE_NONE)
    else $error("restart did not clear fault code");

  fault_read_clear_a: assert property (
    rd_fault && prdata[3:0] == fault_code_reg && first_code == `CODE_NONE
    |=> fault_code_reg == `CODE_NONE)
    else $error("read did not clear fault code");

  code_core_a: assert property (
    fault_code_reg == `CODE_NONE && flag_rise[1] |=> fault_code_reg == `CODE_CORE_OV)
    else $error("core overvoltage code wrong");

  code_fast_a: assert property (
    fault_code_reg == `CODE_NONE && flag_rise[4] && flag_rise[3:1] == '0
    |=> fault_code_reg == `CODE_CUR_FAST)
    else $error("fast trip code wrong");

  code_load_a: assert property (
    fault_code_reg == `CODE_NONE && $rose(load_side_overvoltage) && flag_rise[6:1] == '0
    |=> fault_code_reg == `CODE_LOAD_OV)
    else $error("load overvoltage code wrong");

  code_temp_a: assert property (
    fault_code_reg == `CODE_NONE && $rose(overtemperature) && flag_rise[9:1] == '0
    |=> fault_code_reg == `CODE_OVERTEMP)
    else $error("overtemperature code wrong");

  code_line_a: assert property (
    fault_code_reg == `CODE_NONE && $rose(line_sense_fault) && flag_rise[14:1] == '0
    |=> fault_code_reg == `CODE_LINE_SENSE)
    else $error("line sense code wrong");

  vin_update_a: assert property (
    div_done |=> vin_reg == $past(div_quo))
    else $error("input voltage not updated");

  vin_bytes_a: assert property (
    rd_vin && second_byte_reg |-> prdata[7:0] == lo_snap_reg && prdata[31:8] == '0)
    else $error("second byte not the snapshot");

  fault_lock_a: assert property (
    fault_code_reg != `CODE_NONE && !fault_clear |=> $stable(fault_code_reg))
    else $error("locked fault code changed");

  fault_cover_c: cover property (fault_code_reg == `CODE_NONE ##1
                                 fault_code_reg != `CODE_NONE);
  vin_pair_c: cover property (rd_vin && !second_byte_reg ##3 rd_vin && second_byte_reg);
  restart_c: cover property (supply_restart && fault_code_reg != `CODE_NONE);
  irq_c: cover property (!irq ##1 irq);

endmodule

// file: logic/ffiv_regs.svh
// register offsets, field codes and timing counts for the first-fault and input-voltage bank
//
// How it works
// - four-bit first-fault code, zero means none
// - supply restart clears the first-fault code
// - reading the code returns it, then clears
// - codes 1-3: core, main overvoltage, checksum
// - codes 4-6: current trip flags
// - codes 7-9: load, local overvoltage, external
// - codes 10-12: overtemperature, undervoltage, reverse
// - codes 13-15: continuity, share bus, line sense
// - input voltage is sense over modulation
// - two reads: upper byte, then lower byte
`ifndef FFIV_REGS_SVH
`define FFIV_REGS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define FAULT_CODE_IDX  8'h10
`define VIN_VALUE_IDX   8'h12
`define IRQ_STATUS_IDX  8'h20
`define IRQ_MASK_IDX    8'h21
`define CONTROL_IDX     8'h22

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define IRQ_FAULT_BIT   0
`define IRQ_VIN_BIT     1
`define IRQ_ZERO_BIT    2
`define IRQ_W           3
`define CTRL_SAMPLE_BIT 0
`define CTRL_RESET      1'b1
`define MASK_RESET      3'h0
`define FAULT_W         4

// ----------------------------------------------------------------
// first-fault codes
// ----------------------------------------------------------------
`define CODE_NONE       4'h0
`define CODE_CORE_OV    4'h1
`define CODE_MAIN_OV    4'h2
`define CODE_CHECKSUM   4'h3
`define CODE_CUR_FAST   4'h4
`define CODE_CUR_PREC   4'h5
`define CODE_OUT_PREC   4'h6
`define CODE_LOAD_OV    4'h7
`define CODE_LOCAL_OV   4'h8
`define CODE_EXT_FAULT  4'h9
`define CODE_OVERTEMP   4'ha
`define CODE_UNDERVOLT  4'hb
`define CODE_REVERSE    4'hc
`define CODE_CONTINUITY 4'hd
`define CODE_SHARE_BUS  4'he
`define CODE_LINE_SENSE 4'hf

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MCLK_PERIOD_NS  32'd50
`define VIN_SAMPLE_NS   32'd10000
`define VIN_SAMPLE_CYC  (`VIN_SAMPLE_NS / `MCLK_PERIOD_NS)

`endif

// file: logic/ffiv_pkg.sv
// types shared by the first-fault and input-voltage bank
package ffiv_pkg;

  typedef enum logic [2:0] {
    DIV_IDLE = 3'b001,
    DIV_RUN  = 3'b010,
    DIV_DONE = 3'b100
  } div_state_t;

  typedef logic [3:0] fault_code_t;

endpackage

// file: logic/vin_divider.sv
// sequential divider: sense scaled by modulation full scale, divided by modulation
`timescale 1ns/1ps
module vin_divider #(
  parameter int SENSE_W = 12,
  parameter int MOD_W   = 8,
  parameter int OUT_W   = 16
) (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               resetn,
  // request
  input  wire logic               start,
  input  wire logic [SENSE_W-1:0] sense,
  input  wire logic [MOD_W-1:0]   modulation,
  // answer
  output logic                    done,
  output logic                    div_zero,
  output logic [OUT_W-1:0]        quotient
);
  localparam int NUM_W = SENSE_W + MOD_W;
  localparam int CNT_W = $clog2(NUM_W + 1);

  ffiv_pkg::div_state_t state_reg;
  logic [NUM_W-1:0]     num_reg;
  logic [NUM_W-1:0]     quo_reg;
  logic [MOD_W:0]       rem_reg;
  logic [MOD_W-1:0]     den_reg;
  logic [CNT_W-1:0]     cnt_reg;
  logic [MOD_W:0]       rem_shift;
  logic [MOD_W:0]       rem_sub;

  assign rem_shift = {rem_reg[MOD_W-1:0], num_reg[NUM_W-1]};
  assign rem_sub   = rem_shift - {1'b0, den_reg};

  // ----------------------------------------------------------------
  // restoring division, one quotient bit a cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_reg <= ffiv_pkg::DIV_IDLE;
      num_reg   <= '0;
      quo_reg   <= '0;
      rem_reg   <= '0;
      den_reg   <= '0;
      cnt_reg   <= '0;
      done      <= 1'b0;
      div_zero  <= 1'b0;
      quotient  <= '0;
    end else begin
      done <= 1'b0;
      unique case (state_reg)
        ffiv_pkg::DIV_IDLE: begin
          if (start) begin
            num_reg   <= {sense, {MOD_W{1'b0}}};
            den_reg   <= modulation;
            rem_reg   <= '0;
            quo_reg   <= '0;
            cnt_reg   <= CNT_W'(NUM_W);
            state_reg <= ffiv_pkg::DIV_RUN;
          end
        end
        ffiv_pkg::DIV_RUN: begin
          num_reg <= {num_reg[NUM_W-2:0], 1'b0};
          if (!rem_sub[MOD_W]) begin
            rem_reg <= rem_sub;
            quo_reg <= {quo_reg[NUM_W-2:0], 1'b1};
          end else begin
            rem_reg <= rem_shift;
            quo_reg <= {quo_reg[NUM_W-2:0], 1'b0};
          end
          cnt_reg <= cnt_reg - 1'b1;
          if (cnt_reg == CNT_W'(1)) begin
            state_reg <= ffiv_pkg::DIV_DONE;
          end
        end
        ffiv_pkg::DIV_DONE: begin
          div_zero <= (den_reg == '0);
          // saturate on zero modulation or overflow
          if (den_reg == '0 || quo_reg[NUM_W-1:OUT_W] != '0) begin
            quotient <= '1;
          end else begin
            quotient <= quo_reg[OUT_W-1:0];
          end
          done      <= 1'b1;
          state_reg <= ffiv_pkg::DIV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  div_exact_a: assert property (@(posedge mclk) disable iff (!resetn)
    (state_reg == ffiv_pkg::DIV_DONE && den_reg != '0 && quo_reg[NUM_W-1:OUT_W] == '0)
    |=> done && quotient == $past(quo_reg[OUT_W-1:0]))
    else $error("quotient not taken from divider");

endmodule

// file: dv/tb_first_fault_and_input_voltage_regs.sv
// self-checking testbench for the first-fault and input-voltage register bank
`timescale 1ns/1ps
`include "ffiv_regs.svh"
module tb_first_fault_and_input_voltage_regs;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int LIMIT = 20000;
  logic        mclk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic [14:0] flags;
  logic        supply_restart;
  logic [11:0] sense;
  logic [7:0]  modulation;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          error_cnt;
  int          checks;
  int          cyc;

  first_fault_and_input_voltage_regs #(.SENSE_W(12), .MOD_W(8), .SAMPLE_CYC(30)) uut (
    .mclk                        (mclk),
    .resetn                      (resetn),
    .psel                        (psel),
    .penable                     (penable),
    .pwrite                      (pwrite),
    .paddr                       (paddr),
    .pwdata                      (pwdata),
    .pready                      (pready),
    .pslverr                     (pslverr),
    .prdata                      (prdata),
    .core_supply_overvoltage     (flags[0]),
    .main_supply_overvoltage     (flags[1]),
    .config_checksum_error       (flags[2]),
    .input_current_fast_trip     (flags[3]),
    .input_current_precise_trip  (flags[4]),
    .output_current_precise_trip (flags[5]),
    .load_side_overvoltage       (flags[6]),
    .local_overvoltage           (flags[7]),
    .external_fault_input        (flags[8]),
    .overtemperature             (flags[9]),
    .undervoltage                (flags[10]),
    .reverse_voltage             (flags[11]),
    .voltage_continuity_error    (flags[12]),
    .share_bus_fault             (flags[13]),
    .line_sense_fault            (flags[14]),
    .supply_restart              (supply_restart),
    .local_output_sense          (sense),
    .pwm_modulation              (modulation),
    .irq                         (irq)
  );

  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one apb transfer; waits for pready with no bound of its own
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    check({31'h0, pready}, 32'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [15:0] vin_exp(input logic [11:0] s, input logic [7:0] m);
    logic [31:0] q;
    if (m == 8'h00) begin
      return 16'hffff;
    end
    q = ({20'h0, s} * 32'h100) / {24'h0, m};
    return (q > 32'hffff) ? 16'hffff : q[15:0];
  endfunction

  task automatic wait_vin();
    int n;
    n = 0;
    apb(1'b1, `IRQ_STATUS_IDX, 32'h2);
    tick(2);
    while (irq !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    check({31'h0, irq}, 32'h1);
  endtask

  task automatic read_pair(input logic [15:0] exp);
    apb(1'b0, `VIN_VALUE_IDX, 32'h0);
    check(rd, {24'h0, exp[15:8]});
    apb(1'b0, `VIN_VALUE_IDX, 32'h0);
    check(rd, {24'h0, exp[7:0]});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic reset_and_map();
    apb(1'b0, `FAULT_CODE_IDX, 32'h0);
    check(rd, 32'h0);
    read_pair(16'h0000);
    apb(1'b0, `IRQ_MASK_IDX, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `CONTROL_IDX, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, 8'h30, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, `FAULT_CODE_IDX, 32'h5);
    check({31'h0, err}, 32'h0);
    apb(1'b0, `FAULT_CODE_IDX, 32'h0);
    check(rd, 32'h0);
  endtask

  task automatic all_codes();
    for (int i = 0; i < 15; i++) begin
      flags[i] <= 1'b1;
      apb(1'b0, `FAULT_CODE_IDX, 32'h0);
      check(rd, i + 1);
      apb(1'b0, `FAULT_CODE_IDX, 32'h0);
      check(rd, 32'h0);
      flags <= 15'h0;
      tick(1);
    end
  endtask

  task automatic lock_and_restart();
    flags[9] <= 1'b1;
    tick(2);
    flags[0] <= 1'b1;
    apb(1'b0, `FAULT_CODE_IDX, 32'h0);
    check(rd, 32'ha);
    flags <= 15'h0;
    tick(2);
    flags <= 15'h0028;
    apb(1'b0, `FAULT_CODE_IDX, 32'h0);
    check(rd, 32'h4);
    flags <= 15'h0004;
    tick(2);
    supply_restart <= 1'b1;
    tick(1);
    supply_restart <= 1'b0;
    apb(1'b0, `FAULT_CODE_IDX, 32'h0);
    check(rd, 32'h0);
    flags <= 15'h0;
  endtask

  task automatic input_voltage();
    apb(1'b1, `IRQ_MASK_IDX, 32'h2);
    sense      <= 12'd2643;
    modulation <= 8'd128;
    wait_vin();
    wait_vin();
    read_pair(vin_exp(12'd2643, 8'd128));
    read_pair(16'd5286);
    apb(1'b0, `VIN_VALUE_IDX, 32'h0);
    apb(1'b0, `FAULT_CODE_IDX, 32'h0);
    apb(1'b0, `VIN_VALUE_IDX, 32'h0);
    check(rd, {16'h0, vin_exp(12'd2643, 8'd128) >> 8});
    sense      <= 12'd1000;
    modulation <= 8'd200;
    tick(70);
    apb(1'b0, `VIN_VALUE_IDX, 32'h0);
    check(rd, {16'h0, vin_exp(12'd2643, 8'd128) & 16'h00ff});
    read_pair(vin_exp(12'd1000, 8'd200));
    modulation <= 8'd0;
    wait_vin();
    wait_vin();
    read_pair(16'hffff);
    apb(1'b0, `IRQ_STATUS_IDX, 32'h0);
    check(rd & 32'h4, 32'h4);
    apb(1'b1, `CONTROL_IDX, 32'h0);
    tick(60);
    apb(1'b1, `IRQ_STATUS_IDX, 32'h7);
    tick(2);
    check({31'h0, irq}, 32'h0);
    apb(1'b0, `IRQ_STATUS_IDX, 32'h0);
    check(rd, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn         = 1'b0;
    psel           = 1'b0;
    penable        = 1'b0;
    pwrite         = 1'b0;
    paddr          = 12'h000;
    pwdata         = 32'h0;
    flags          = 15'h0;
    supply_restart = 1'b0;
    sense          = 12'h000;
    modulation     = 8'h80;
    error_cnt      = 0;
    checks         = 0;
    tick(4);
    resetn <= 1'b1;
    reset_and_map();
    all_codes();
    lock_and_restart();
    input_voltage();
    end_sim();
  end
endmodule
